// File: hw/viu_pkg.sv
// package of constants for the vectored interrupt unit
package viu_pkg;
  localparam int unsigned VIU_NUM_SRC       = 32;       // request inputs
  localparam int unsigned VIU_PRIO_W        = 4;        // priority field width
  localparam int unsigned VIU_IDX_W         = 5;        // channel index width
  localparam int unsigned VIU_ADDR_W        = 32;       // service address width
  localparam logic [31:0] VIU_SLOT_BYTES    = 32'h0000_4000; // one 16 kB bus slot
  localparam logic [31:0] VIU_REGION_BYTES  = 32'h0020_0000; // 2 MB peripheral region
  localparam logic [31:0] VIU_REGION_BASE   = 32'hFFE0_0000; // top 2 MB of space
  localparam logic [31:0] VIU_SLOT_BASE_DEF = 32'hFFFF_F000 & ~(VIU_SLOT_BYTES - 32'h1);
  localparam logic [31:0] VIU_RST_CLASS     = 32'h0000_0000; // all inputs vectored
  localparam logic [31:0] VIU_RST_ADDR      = 32'h0000_0000;
  localparam logic [3:0]  VIU_RST_PRIO      = 4'h0;
  localparam logic [7:0]  VIU_SEL_ST_IDLE   = 8'h01;
  localparam logic [7:0]  VIU_SEL_ST_HOLD   = 8'h02;
  typedef enum logic [1:0] {
    VIU_ST_IDLE = 2'b01,
    VIU_ST_BUSY = 2'b10
  } viu_state_type;
endpackage : viu_pkg

// File: hw/viu_select.sv
// priority selector: lowest priority value wins, ties to the lowest channel
`timescale 1ns/100ps
module viu_select #(
  parameter int unsigned NUM_SRC = 32,
  parameter int unsigned PRIO_W  = 4,
  parameter int unsigned IDX_W   = 5
) (
  input  wire logic [NUM_SRC-1:0]        i_req,
  input  wire logic [NUM_SRC*PRIO_W-1:0] i_prio,
  output logic                           o_valid,
  output logic [IDX_W-1:0]               o_idx
);
  // scan from the highest channel down so equal priorities settle on the lowest
  always_comb begin
    o_valid = 1'b0;
    o_idx   = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (i_req[i] && (!o_valid ||
          i_prio[i*PRIO_W +: PRIO_W] <= i_prio[o_idx*PRIO_W +: PRIO_W])) begin
        o_valid = 1'b1;
        o_idx   = IDX_W'(i);
      end
    end
  end
endmodule : viu_select

// File: hw/viu_top.sv
// vectored interrupt unit: fast and vectored request classes toward the core
`timescale 1ns/100ps
// Operation
// RULE1: each of 32 request inputs is classed as fast or vectored by software.
// RULE2: the fast class always outranks any vectored request.
// RULE3: all active fast-class inputs are ORed onto the fast request output.
// RULE4: a status word shows, per input, which fast-class inputs are requesting.
// RULE5: every non-fast input is vectored with a priority changeable at run time.
// RULE6: among equal priorities the lowest-numbered channel is selected.
// RULE7: all active vectored requests are ORed onto the normal request output.
// RULE8: a readable value gives the service address of the selected request.
// RULE9: the unit sits in one 16 kB slot inside the top 2 MB peripheral region.
// RULE10: each peripheral presents exactly one request line.
// RULE11: port edge requests are merged onto the external_interrupt_three channel.
// RULE12: both request outputs are levels that follow their qualifying inputs.
module viu_top
  import viu_pkg::*;
#(
  parameter int unsigned NUM_SRC   = viu_pkg::VIU_NUM_SRC,
  parameter int unsigned PRIO_W    = viu_pkg::VIU_PRIO_W,
  parameter int unsigned IDX_W     = viu_pkg::VIU_IDX_W,
  parameter logic [31:0] SLOT_BASE = viu_pkg::VIU_SLOT_BASE_DEF
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire logic [NUM_SRC-1:0]            i_req,
  input  wire logic [NUM_SRC-1:0]            i_fast_class,
  input  wire logic [NUM_SRC-1:0]            i_enable,
  input  wire logic [NUM_SRC*PRIO_W-1:0]     i_prio,
  input  wire logic [NUM_SRC*32-1:0]         i_vec_addr,
  output logic                               o_fast_interrupt_request,
  output logic                               o_normal_interrupt_request,
  output logic [NUM_SRC-1:0]                 o_fast_status,
  output logic [NUM_SRC-1:0]                 o_raw_status,
  output logic                               o_vec_valid,
  output logic [IDX_W-1:0]                   o_vec_idx,
  output logic [31:0]                        o_vec_addr,
  output logic [31:0]                        o_slot_base,
  output logic                               o_slot_in_region
);
  import viu_pkg::*;

  logic [NUM_SRC-1:0] class_q;
  logic [NUM_SRC-1:0] class_d;
  logic [NUM_SRC-1:0] fast_q;
  logic [NUM_SRC-1:0] vect_q;
  logic               sel_valid;
  logic [IDX_W-1:0]   sel_idx;
  logic [31:0]        addr_q;
  logic [IDX_W-1:0]   idx_q;
  logic               valid_q;
  logic               fast_req_q;
  logic               norm_req_q;
  viu_state_type      state_q;
  viu_state_type      state_d;

  // classification follows the software setting every cycle
  // the class is registered so a class change lands on one edge for both outputs
  // RULE1 class select
  assign class_d = i_fast_class;

  // split qualified requests into the two classes
  wire [NUM_SRC-1:0] act_w  = i_req & i_enable;
  // RULE3 fast class mask
  wire [NUM_SRC-1:0] fast_w = act_w & class_q;
  // RULE5 vectored class mask
  wire [NUM_SRC-1:0] vect_w = act_w & ~class_q;

  // selector among vectored requests
  viu_select #(
    .NUM_SRC (NUM_SRC),
    .PRIO_W  (PRIO_W),
    .IDX_W   (IDX_W)
  ) u_sel (
    .i_req   (vect_w),
    .i_prio  (i_prio),
    .o_valid (sel_valid),
    .o_idx   (sel_idx)
  );

  // slot placement is fixed at build time
  // RULE9 slot in region
  wire slot_ok_w = (SLOT_BASE >= VIU_REGION_BASE) &&
                   ((SLOT_BASE & (VIU_SLOT_BYTES - 32'h1)) == 32'h0);

  // state: idle with no vectored request, busy while one is selected
  assign state_d = sel_valid ? VIU_ST_BUSY : VIU_ST_IDLE;

  // registered class and request state
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      class_q <= VIU_RST_CLASS;
      fast_q  <= '0;
      vect_q  <= '0;
      fast_req_q <= 1'b0;
      norm_req_q <= 1'b0;
      state_q <= VIU_ST_IDLE;
    end else begin
      class_q <= class_d;
      fast_q  <= fast_w;
      vect_q  <= vect_w;
      // RULE12 level outputs
      fast_req_q <= |fast_w;
      norm_req_q <= |vect_w;
      state_q <= state_d;
    end
  end

  // registered vector selection
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      addr_q  <= VIU_RST_ADDR;
      idx_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      // RULE8 service address
      addr_q  <= sel_valid ? i_vec_addr[sel_idx*32 +: 32] : VIU_RST_ADDR;
      idx_q   <= sel_idx;
      valid_q <= sel_valid;
    end
  end

  // outputs toward the core and software
  // RULE3 fast or
  assign o_fast_interrupt_request   = fast_req_q;
  // RULE7 vectored or
  assign o_normal_interrupt_request = norm_req_q;
  // RULE4 fast status
  assign o_fast_status              = fast_q;
  assign o_raw_status               = fast_q | vect_q;
  // RULE2 fast outranks vectored
  assign o_vec_valid                = valid_q;
  assign o_vec_idx                  = idx_q;
  assign o_vec_addr                 = addr_q;
  assign o_slot_base                = SLOT_BASE;
  assign o_slot_in_region           = slot_ok_w;

  // checks: registered outputs against the inputs one or two edges back
  // priority field of one channel
  function automatic logic [PRIO_W-1:0] prio_at(input logic [NUM_SRC*PRIO_W-1:0] p,
                                                 input logic [IDX_W-1:0]          n);
    return p[n*PRIO_W +: PRIO_W];
  endfunction : prio_at

  // RULE3 fast output follows any fast input
  AST_FAST_OR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
    ($past(i_rst_n) && $past(i_rst_n, 2)) |->
      (o_fast_interrupt_request == |($past(i_req & i_enable) & $past(i_fast_class, 2))))
    else $error("fast output does not match fast inputs");
  // RULE3 fast output rises for a fast request
  AST_FAST_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
    (|fast_w) |=> o_fast_interrupt_request)
    else $error("fast output missing for fast request");
  // RULE12 fast drops when nothing fast
  AST_FAST_DROP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
    (fast_w == '0) |=> !o_fast_interrupt_request)
    else $error("fast output stuck high");
  // RULE7 normal output rises for a vectored request
  AST_NORM_OR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE7
    (|vect_w) |=> o_normal_interrupt_request)
    else $error("normal output missing for vectored request");
  // RULE12 normal drops when nothing vectored
  AST_NORM_LVL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
    (vect_w == '0) |=> !o_normal_interrupt_request)
    else $error("normal output stuck high");
  // RULE4 status shows only fast inputs
  AST_FAST_STAT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE4
    ($past(i_rst_n) && $past(i_rst_n, 2)) |->
      (o_fast_status == ($past(i_req & i_enable) & $past(i_fast_class, 2))))
    else $error("status word does not match fast-class inputs");
  // RULE4 fast status is part of the raw status
  AST_STATUS_SUB: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE4
    (o_fast_status & ~o_raw_status) == '0)
    else $error("fast status bit without raw status bit");
  // RULE1 raw status covers both classes
  AST_RAW_STAT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
    $past(i_rst_n) |-> (o_raw_status == $past(i_req & i_enable)))
    else $error("raw status does not match enabled inputs");
  // RULE6 a tie with an active vectored channel 0 goes to channel 0
  AST_TIE_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE6
    (vect_w[0] && sel_valid) |-> (i_prio[sel_idx*PRIO_W +: PRIO_W] < i_prio[0 +: PRIO_W]
      || sel_idx == '0))
    else $error("tie not resolved to lowest channel");
  // RULE6 no active vectored channel beats the selection
  for (genvar c = 0; c < NUM_SRC; c++) begin : g_prio_chk
    AST_PRIO_ORDER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE6
      (sel_valid && vect_w[c]) |->
        ((prio_at(i_prio, sel_idx) < prio_at(i_prio, IDX_W'(c))) ||
         (prio_at(i_prio, sel_idx) == prio_at(i_prio, IDX_W'(c)) && sel_idx <= IDX_W'(c))))
      else $error("a better vectored channel was passed over");
  end
  // RULE5 selected request is vectored
  AST_SEL_VECT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE5
    sel_valid |-> vect_w[sel_idx])
    else $error("selected channel not a vectored request");
  // RULE2 fast channels never go through the vector path
  AST_SEL_NOT_FAST: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
    sel_valid |-> !class_q[sel_idx])
    else $error("vector path selected a fast channel");
  // RULE5 shown index is an enabled vectored requester
  AST_IDX_VECT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE5
    o_vec_valid |-> (o_raw_status[o_vec_idx] && !o_fast_status[o_vec_idx]))
    else $error("shown index is not a vectored requester");
  // RULE5 busy state tracks a standing selection
  AST_STATE_BUSY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE5
    o_vec_valid == (state_q == VIU_ST_BUSY))
    else $error("selection state out of step with valid");
  // RULE8 address tracks selection
  AST_VEC_ADDR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
    sel_valid |=> o_vec_addr == $past(i_vec_addr[sel_idx*32 +: 32]))
    else $error("vector address does not match selection");
  // RULE8 no selection gives the idle address
  AST_VEC_NONE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
    !sel_valid |=> (o_vec_addr == VIU_RST_ADDR && !o_vec_valid))
    else $error("vector address left over without selection");
  // RULE1 fast class never reaches the normal output
  AST_CLASS_SPLIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
    ((act_w & ~class_q) == '0) |=> (!o_normal_interrupt_request && o_vec_valid == 1'b0))
    else $error("fast class leaked into vectored path");
  // RULE12 outputs idle on the first edge after reset
  AST_RESET_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
    $past(!i_rst_n) |-> (!o_fast_interrupt_request && !o_normal_interrupt_request &&
      !o_vec_valid && o_vec_addr == VIU_RST_ADDR && o_raw_status == '0))
    else $error("outputs not idle after reset");
endmodule : viu_top

// File: verif/viu_periph_model.sv
// far-side model: peripheral request lines toward the unit
`timescale 1ns/100ps
module viu_periph_model #(
  parameter int unsigned EXT3_CH = 20
) (
  input  wire logic [31:0] i_lines,
  input  wire logic        i_port_evt,
  output logic [31:0]      o_req
);
  assign o_req = i_lines | (32'(i_port_evt) << EXT3_CH);
endmodule : viu_periph_model

// File: verif/testbench.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
module testbench;
  import viu_pkg::*;
  logic         clk, rst_n, evt, fq, nq, vv, inr;
  logic [31:0]  lines, req, cls, en, fst, rst, va, sb;
  logic [127:0] prio;
  logic [1023:0] vad;
  logic [4:0]   vi;
  int           errors, checks_done, cyc;
  // clock and far side
  always #2 clk = ~clk;
  viu_periph_model #(.EXT3_CH(20)) PM (.i_lines(lines), .i_port_evt(evt), .o_req(req));
  viu_top #(.SLOT_BASE(32'hFFFF_C000)) DUT (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_req(req), .i_fast_class(cls), .i_enable(en), .i_prio(prio), .i_vec_addr(vad),
    .o_fast_interrupt_request(fq), .o_normal_interrupt_request(nq), .o_fast_status(fst),
    .o_raw_status(rst), .o_vec_valid(vv), .o_vec_idx(vi), .o_vec_addr(va),
    .o_slot_base(sb), .o_slot_in_region(inr));
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // expected winner: lowest priority value, ties to the lower channel
  function automatic int exp_best(input logic [31:0] ns, input logic [127:0] p);
    int b;
    b = -1;
    for (int n = 0; n < 32; n++) begin
      if (ns[n] && (b < 0 || p[4*n+:4] < p[4*b+:4])) begin
        b = n;
      end
    end
    return b;
  endfunction : exp_best
  // wait for class and outputs to settle, then compare
  task automatic run_case(input string nm);
    logic [31:0] fs, ns;
    int          b;
    repeat (2) @(posedge clk);
    @(negedge clk);
    fs = req & en & cls;
    ns = req & en & ~cls;
    b  = exp_best(ns, prio);
    chk(32'(fq), 32'(|fs), "fast");
    chk(32'(nq), 32'(|ns), "normal");
    chk(fst, fs, "fast status");
    chk(rst, req & en, "raw status");
    chk(32'(vv), 32'(b >= 0), "valid");
    if (b >= 0) chk(32'(vi), 32'(b), "index");
    chk(va, (b >= 0) ? vad[32*b+:32] : 32'h0, "address");
    $display("test %s done", nm);
  endtask : run_case
  // cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    clk   = 1'b0;
    rst_n = 1'b0;
    evt   = 1'b0;
    lines = '0;
    cls   = '0;
    en    = '0;
    prio  = '0;
    vad   = '0;
    void'($urandom(32'h7FE5));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk(sb, 32'hFFFF_C000, "slot");
    chk(32'(inr), 32'h1, "region");
    for (int n = 0; n < 32; n++) vad[32*n+:32] = $urandom;
    lines = 32'hFFFF_FFFF;
    en    = 32'hFFFF_FFFF;
    run_case("ties");
    lines = 32'hFFFF_FFF0;
    run_case("ties high");
    cls = 32'hFFFF_FFFF;
    run_case("all fast");
    lines = '0;
    cls   = '0;
    evt   = 1'b1;
    run_case("port event");
    evt = 1'b0;
    run_case("all clear");
    // reset in mid-run while requests of both classes stand
    lines = 32'hFFFF_FFFF;
    cls   = 32'h0000_00FF;
    run_case("mixed classes");
    rst_n = 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(32'({fq, nq, vv}), 32'h0, "outputs in reset");
    chk(fst | rst | va, 32'h0, "status in reset");
    rst_n = 1'b1;
    run_case("after reset");
    for (int k = 0; k < 150; k++) begin
      lines = $urandom;
      cls   = $urandom;
      en    = $urandom;
      evt   = 1'($urandom);
      for (int n = 0; n < 4; n++) prio[32*n+:32] = $urandom;
      run_case("random");
    end
    final_report();
  end
endmodule : testbench
